// ### rtl/tmc_unit.sv
// Timer unit: register port, channel control, prescaler, input sampling and interrupts.
`timescale 1ns/10ps
`include "tmc_map.svh"
module tmc_unit #(
    parameter int NUM_CH = `TMC_MAX_CH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire tmc_pkg::tmc_bus_req_t bus,
    output logic [15:0] rd_data,
    input wire logic [NUM_CH-1:0] channel_timer_input,
    output logic [NUM_CH-1:0] channel_timer_output,
    output logic [NUM_CH-1:0] channel_interrupt,
    output logic irq
);
    typedef struct packed {
        logic unit_en;
        logic [3:0] psc;
        logic [14:0] div;
        logic tick;
        logic [NUM_CH-1:0] run;
        logic [NUM_CH-1:0] fresh;
        logic [NUM_CH-1:0] start;
        logic [NUM_CH-1:0] stop;
        logic [NUM_CH-1:0] wr_data;
        logic [15:0] wdata;
        logic [NUM_CH-1:0] sync1;
        logic [NUM_CH-1:0] sync2;
        logic [NUM_CH-1:0] prev;
        logic [NUM_CH-1:0] rise;
        logic [NUM_CH-1:0] fall;
        logic [NUM_CH-1:0] status;
        logic [NUM_CH-1:0] mask;
        logic [NUM_CH-1:0] tout;
        logic [NUM_CH-1:0] intr;
        logic irq;
        logic [15:0] rdata;
        tmc_pkg::tmc_cfg_t [NUM_CH-1:0] cfg;
    } tmc_top_t;

    tmc_top_t s_q;
    tmc_top_t s_d;
    tmc_pkg::tmc_core_t core_st [NUM_CH];
    tmc_pkg::tmc_ctl_t core_ctl [NUM_CH];
    logic [NUM_CH-1:0] core_irq;
    logic [NUM_CH-1:0] wmask;
    logic [15:0] div_mask;

    // Address of the count register of channel n.
    function automatic logic [19:0] tmc_count_addr(input int n);
        return `TMC_COUNT_BASE + 20'(n) * `TMC_REG_STRIDE;
    endfunction

    // Address of the mode configuration register of channel n.
    function automatic logic [19:0] tmc_cfg_addr(input int n);
        return `TMC_CFG_BASE + 20'(n) * `TMC_REG_STRIDE;
    endfunction

    // The data registers sit in two separate windows.
    function automatic logic [19:0] tmc_data_addr(input int n);
        logic [19:0] a;
        if (n < `TMC_DATA_LO_CNT)
        begin
            a = `TMC_DATA_BASE_LO + 20'(n) * `TMC_REG_STRIDE;
        end
        else
        begin
            a = `TMC_DATA_BASE_HI + 20'(n - `TMC_DATA_LO_CNT) * `TMC_REG_STRIDE;
        end
        return a;
    endfunction

    generate
        if (NUM_CH < 1 || NUM_CH > `TMC_MAX_CH)
        begin : g_bad
            $error("NUM_CH must lie between 1 and 8");
        end
    endgenerate

    generate
        for (genvar n = 0; n < NUM_CH; n++)
        begin : g_ch
            always_comb
            begin
                core_ctl[n].unit_en = s_q.unit_en;
                core_ctl[n].start = s_q.start[n];
                core_ctl[n].stop = s_q.stop[n];
                core_ctl[n].fresh = s_q.fresh[n];
                core_ctl[n].tick = s_q.tick;
                core_ctl[n].rise = s_q.rise[n];
                core_ctl[n].fall = s_q.fall[n];
                core_ctl[n].wr_data = s_q.wr_data[n];
                core_ctl[n].wdata = s_q.wdata;
                core_ctl[n].cfg = s_q.cfg[n];
            end

            tmc_chan_core u_core (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .ctl(core_ctl[n]),
                .core(core_st[n])
            ); // R15

            assign core_irq[n] = core_st[n].irq;
        end
    endgenerate

    assign rd_data = s_q.rdata;
    assign channel_timer_output = s_q.tout;
    assign channel_interrupt = s_q.intr;
    assign irq = s_q.irq;

    always_comb
    begin
        s_d = s_q;
        wmask = '0;
        div_mask = (16'h0001 << s_q.psc) - 16'h0001;

        // Pin inputs pass two flip-flops before the edge detector sees them.
        s_d.sync1 = channel_timer_input;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        s_d.rise = s_q.sync2 & ~s_q.prev;
        s_d.fall = ~s_q.sync2 & s_q.prev;

        // Prescaled count clock as a one-cycle enable, never a derived clock.
        s_d.div = s_q.div + 15'h0001;
        s_d.tick = (s_q.div & div_mask[14:0]) == div_mask[14:0]; // R17

        // Command strobes toward the cores last one cycle.
        s_d.start = '0;
        s_d.stop = '0;
        s_d.wr_data = '0;
        s_d.fresh = s_q.fresh & ~s_q.start;

        // Interrupt events are sticky; a clear in the same cycle loses to a new event.
        if (bus.wr && bus.addr == `TMC_STAT_ADDR && s_q.unit_en)
        begin
            wmask = bus.wdata[NUM_CH-1:0];
        end
        s_d.status = (s_q.status & ~wmask) | core_irq;
        s_d.intr = core_irq;
        s_d.tout = s_q.tout ^ core_irq;
        s_d.irq = |(s_q.status & s_q.mask);

        if (bus.wr)
        begin
            if (bus.addr == `TMC_UNIT_ADDR)
            begin
                s_d.unit_en = bus.wdata[`TMC_UNIT_EN_BIT];
            end
            if (s_q.unit_en)
            begin
                if (bus.addr == `TMC_PSC_ADDR)
                begin
                    s_d.psc = bus.wdata[`TMC_PSC_W-1:0];
                end
                if (bus.addr == `TMC_MASK_ADDR)
                begin
                    s_d.mask = bus.wdata[NUM_CH-1:0];
                end
                if (bus.addr == `TMC_START_ADDR)
                begin
                    s_d.start = bus.wdata[NUM_CH-1:0];
                    s_d.run = s_q.run | bus.wdata[NUM_CH-1:0];
                end
                if (bus.addr == `TMC_STOP_ADDR)
                begin
                    s_d.stop = bus.wdata[NUM_CH-1:0];
                    s_d.run = s_q.run & ~bus.wdata[NUM_CH-1:0];
                end
                for (int n = 0; n < NUM_CH; n++)
                begin
                    // Mode rewrites are refused while the channel runs.
                    if (bus.addr == tmc_cfg_addr(n) && !s_q.run[n])
                    begin
                        s_d.cfg[n] = tmc_pkg::tmc_cfg_t'(bus.wdata[`TMC_CFG_W-1:0]); // R10
                        s_d.fresh[n] = 1'b1; // R7
                    end
                    if (bus.addr == tmc_data_addr(n))
                    begin
                        s_d.wr_data[n] = 1'b1; // R11
                        s_d.wdata = bus.wdata;
                    end
                end
            end
        end

        s_d.rdata = '0;
        if (bus.rd)
        begin
            if (bus.addr == `TMC_UNIT_ADDR)
            begin
                s_d.rdata = {15'h0000, s_q.unit_en};
            end
            if (bus.addr == `TMC_PSC_ADDR)
            begin
                s_d.rdata = {12'h000, s_q.psc};
            end
            if (bus.addr == `TMC_RUN_ADDR)
            begin
                s_d.rdata[NUM_CH-1:0] = s_q.run;
            end
            if (bus.addr == `TMC_STAT_ADDR)
            begin
                s_d.rdata[NUM_CH-1:0] = s_q.status;
            end
            if (bus.addr == `TMC_MASK_ADDR)
            begin
                s_d.rdata[NUM_CH-1:0] = s_q.mask;
            end
            for (int n = 0; n < NUM_CH; n++)
            begin
                // A read only selects the value; nothing is copied or cleared.
                if (bus.addr == tmc_count_addr(n))
                begin
                    s_d.rdata = core_st[n].count; // R6 R1
                end
                if (bus.addr == tmc_cfg_addr(n))
                begin
                    s_d.rdata = {10'h000, s_q.cfg[n]};
                end
                if (bus.addr == tmc_data_addr(n))
                begin
                    s_d.rdata = core_st[n].data; // R10
                end
            end
        end

        // A disabled unit holds its own registers at their reset values.
        if (!s_q.unit_en)
        begin
            s_d.psc = '0; // R16
            s_d.div = '0;
            s_d.run = '0;
            s_d.fresh = '1; // R7
            s_d.status = '0;
            s_d.mask = '0;
            s_d.tout = '0;
            s_d.intr = '0;
            s_d.irq = 1'b0;
            for (int n = 0; n < NUM_CH; n++)
            begin
                s_d.cfg[n] = '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
            s_q.fresh <= '1; // R7
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

// ### rtl/tmc_map.svh
// Register offsets, field positions and reset values of the timer channel unit.
// What this block does
// R1: Channel counter is 16-bit, read-only, and steps on a count clock tick, or on the selected input edge in event mode.
// R2: Interval, event and one-count modes count down; capture modes count up.
// R3: Counter presets to all ones on reset and when the unit enable clears.
// R4: Counter presets to all ones when a combination channel finishes counting.
// R5: Capture mode clears the counter on its start trigger and after each capture.
// R6: Reading the counter has no side effect and never copies it into data.
// R7: Start after a mode change shows all ones when counting down, zero when up.
// R8: After a stop the counter keeps its stop value until counting really resumes.
// R9: Waiting after one count shows all ones, or captured value plus one.
// R10: Each channel has a 16-bit data register, compare or capture by mode.
// R11: Data register is writable as a whole word while the unit is enabled and resets to zero.
// R12: Compare use loads data, counts down, pulses the interrupt at zero.
// R13: Capture triggers are ignored while the data register is in compare use.
// R14: Capture use copies the counter into data on the selected input edge.
// R15: A unit holds up to eight channels, each with counter, data, input, output.
// R16: With the unit enable low, registers stay in reset and writes are ignored.
// R17: The count clock is a one-cycle enable on the peripheral clock.
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_MAX_CH 8
`define TMC_ADDR_W 20
`define TMC_DATA_W 16
`define TMC_CFG_W 6
`define TMC_PSC_W 4
`define TMC_DIV_W 15
`define TMC_UNIT_EN_BIT 0
`define TMC_UNIT_ADDR 20'hf00f0
`define TMC_COUNT_BASE 20'hf0180
`define TMC_CFG_BASE 20'hf0190
`define TMC_RUN_ADDR 20'hf01b0
`define TMC_START_ADDR 20'hf01b2
`define TMC_STOP_ADDR 20'hf01b4
`define TMC_PSC_ADDR 20'hf01b6
`define TMC_STAT_ADDR 20'hf0240
`define TMC_MASK_ADDR 20'hf0242
`define TMC_DATA_BASE_LO 20'hfff18
`define TMC_DATA_BASE_HI 20'hfff64
`define TMC_DATA_LO_CNT 2
`define TMC_REG_STRIDE 20'h00002
`define TMC_COUNT_RST 16'hffff
`define TMC_DATA_RST 16'h0000
`define TMC_ZERO 16'h0000
`define TMC_ONE 16'h0001
`endif

// ### rtl/tmc_pkg.sv
// Types shared by the timer channel unit and its channel core.
package tmc_pkg;
    typedef enum logic [2:0] {
        TMC_MODE_INTERVAL = 3'h0,
        TMC_MODE_CAPTURE = 3'h2,
        TMC_MODE_EVENT = 3'h3,
        TMC_MODE_ONE_COUNT = 3'h4,
        TMC_MODE_CAP_ONE = 3'h6
    } tmc_mode_t;

    typedef enum logic [1:0] {
        TMC_ST_IDLE = 2'h0,
        TMC_ST_LOAD = 2'h1,
        TMC_ST_WAIT = 2'h2,
        TMC_ST_COUNT = 2'h3
    } tmc_st_t;

    typedef struct packed {
        logic combo_preset;
        logic trig_both;
        logic edge_fall;
        tmc_mode_t mode;
    } tmc_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [19:0] addr;
        logic [15:0] wdata;
    } tmc_bus_req_t;

    typedef struct packed {
        logic unit_en;
        logic start;
        logic stop;
        logic fresh;
        logic tick;
        logic rise;
        logic fall;
        logic wr_data;
        logic [15:0] wdata;
        tmc_cfg_t cfg;
    } tmc_ctl_t;

    typedef struct packed {
        tmc_st_t st;
        logic [15:0] count;
        logic [15:0] data;
        logic irq;
    } tmc_core_t;

    function automatic logic tmc_is_down(input tmc_mode_t mode);
        return !(mode == TMC_MODE_CAPTURE || mode == TMC_MODE_CAP_ONE);
    endfunction
endpackage

// ### rtl/tmc_chan_core.sv
// Counter and data register of one timer channel.
`timescale 1ns/10ps
`include "tmc_map.svh"
module tmc_chan_core (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire tmc_pkg::tmc_ctl_t ctl,
    output tmc_pkg::tmc_core_t core
);
    tmc_pkg::tmc_core_t s_q;
    tmc_pkg::tmc_core_t s_d;
    logic down;
    logic cnt_en;
    logic start_edge;
    logic cap_edge;

    assign core = s_q;

    always_comb
    begin
        s_d = s_q;
        s_d.irq = 1'b0;
        down = tmc_pkg::tmc_is_down(ctl.cfg.mode); // R2
        start_edge = ctl.cfg.edge_fall ? ctl.fall : ctl.rise;
        cap_edge = start_edge;
        if (ctl.cfg.trig_both)
        begin
            cap_edge = ctl.cfg.edge_fall ? ctl.rise : ctl.fall;
        end
        // Event mode counts selected input edges instead of the prescaled tick.
        cnt_en = (ctl.cfg.mode == tmc_pkg::TMC_MODE_EVENT) ? start_edge : ctl.tick; // R17
        if (ctl.wr_data)
        begin
            s_d.data = ctl.wdata; // R11
        end
        unique case (s_q.st)
            tmc_pkg::TMC_ST_IDLE:
            begin
                if (ctl.start)
                begin
                    if (ctl.fresh)
                    begin
                        s_d.count = down ? `TMC_COUNT_RST : `TMC_ZERO; // R7
                    end
                    if (ctl.cfg.mode == tmc_pkg::TMC_MODE_ONE_COUNT ||
                        ctl.cfg.mode == tmc_pkg::TMC_MODE_CAP_ONE)
                    begin
                        s_d.st = tmc_pkg::TMC_ST_WAIT;
                    end
                    else
                    begin
                        s_d.st = tmc_pkg::TMC_ST_LOAD; // R8
                    end
                end
            end
            tmc_pkg::TMC_ST_WAIT:
            begin
                if (start_edge || ctl.start)
                begin
                    s_d.st = tmc_pkg::TMC_ST_LOAD;
                end
            end
            tmc_pkg::TMC_ST_LOAD:
            begin
                if (cnt_en)
                begin
                    s_d.count = down ? s_q.data : `TMC_ZERO; // R12 R5
                    s_d.st = tmc_pkg::TMC_ST_COUNT;
                end
            end
            tmc_pkg::TMC_ST_COUNT:
            begin
                if (down)
                begin
                    if (cnt_en && s_q.count == `TMC_ZERO)
                    begin
                        s_d.irq = 1'b1; // R12
                        if (ctl.cfg.combo_preset)
                        begin
                            s_d.count = `TMC_COUNT_RST; // R4
                            s_d.st = tmc_pkg::TMC_ST_WAIT;
                        end
                        else if (ctl.cfg.mode == tmc_pkg::TMC_MODE_ONE_COUNT)
                        begin
                            s_d.count = `TMC_COUNT_RST; // R9
                            s_d.st = tmc_pkg::TMC_ST_WAIT;
                        end
                        else
                        begin
                            s_d.count = s_q.data;
                        end
                    end
                    else if (cnt_en)
                    begin
                        s_d.count = s_q.count - `TMC_ONE; // R1
                    end
                end
                else if (cap_edge)
                begin
                    // A capture beats a software write to data in the same cycle.
                    s_d.data = s_q.count; // R14 R13
                    s_d.irq = 1'b1;
                    if (ctl.cfg.mode == tmc_pkg::TMC_MODE_CAP_ONE)
                    begin
                        s_d.count = s_q.count + `TMC_ONE; // R9
                        s_d.st = tmc_pkg::TMC_ST_WAIT;
                    end
                    else
                    begin
                        s_d.count = `TMC_ZERO; // R5
                    end
                end
                else if (cnt_en)
                begin
                    s_d.count = s_q.count + `TMC_ONE; // R1
                end
            end
        endcase
        if (ctl.stop)
        begin
            s_d.st = tmc_pkg::TMC_ST_IDLE; // R8
        end
        if (!ctl.unit_en)
        begin
            s_d.st = tmc_pkg::TMC_ST_IDLE;
            s_d.count = `TMC_COUNT_RST; // R3
            s_d.data = `TMC_DATA_RST; // R16
            s_d.irq = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q.st <= tmc_pkg::TMC_ST_IDLE;
            s_q.count <= `TMC_COUNT_RST; // R3
            s_q.data <= `TMC_DATA_RST; // R11
            s_q.irq <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule

// ### verif/tmc_unit_properties.sv
// Port-level assertions for the timer unit, bound to its top module.
`timescale 1ns/10ps
`include "tmc_map.svh"
module tmc_unit_properties #(
    parameter int NUM_CH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire tmc_pkg::tmc_bus_req_t bus,
    input wire logic [15:0] rd_data,
    input wire logic [NUM_CH-1:0] channel_timer_input,
    input wire logic [NUM_CH-1:0] channel_timer_output,
    input wire logic [NUM_CH-1:0] channel_interrupt,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic en_q;
    logic run_q;
    logic [2:0] off_q;
    // The unit enable and start are rebuilt from the bus, as the internals are out of view.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_q <= 1'b0;
            run_q <= 1'b0;
            off_q <= 3'h0;
        end
        else
        begin
            if (bus.wr && bus.addr == `TMC_UNIT_ADDR)
                en_q <= bus.wdata[0];
            if (bus.wr && bus.addr == `TMC_START_ADDR && bus.wdata != 16'h0000 && en_q)
                run_q <= 1'b1;
            if (en_q)
                off_q <= 3'h0;
            else if (off_q != 3'h7)
                off_q <= off_q + 3'h1;
        end
    end
    property p_rd_quiet;
        !$past(bus.rd) |-> rd_data == 16'h0000;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
    property p_wr_quiet;
        bus.wr |=> rd_data == 16'h0000;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("write produced read data");
    property p_tout_toggle;
        en_q && $past(en_q) && $past(en_q, 2)
            |-> (channel_timer_output ^ $past(channel_timer_output)) == channel_interrupt;
    endproperty
    a_tout_toggle: assert property (p_tout_toggle) else $error("output toggle without event");
    property p_off_quiet;
        off_q == 3'h7 |-> channel_interrupt == '0 && !irq;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("event while unit disabled");
    property p_off_data;
        off_q == 3'h7 && bus.rd && bus.addr == `TMC_DATA_BASE_LO |=> rd_data == `TMC_DATA_RST;
    endproperty
    a_off_data: assert property (p_off_data) else $error("data not reset while off");
    property p_irq_rise;
        $rose(irq) |-> $past(|channel_interrupt) || $past(bus.wr, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(bus.wr) || $past(bus.wr, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_int_run;
        |channel_interrupt |-> $past(run_q, 3);
    endproperty
    a_int_run: assert property (p_int_run) else $error("event before any start");
endmodule
bind tmc_unit tmc_unit_properties #(.NUM_CH(NUM_CH)) chk_u (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .bus(bus),
    .rd_data(rd_data),
    .channel_timer_input(channel_timer_input),
    .channel_timer_output(channel_timer_output),
    .channel_interrupt(channel_interrupt),
    .irq(irq)
);

// ### verif/tb.sv
// Self-checking testbench for the timer unit.
`timescale 1ns/10ps
`include "tmc_map.svh"
module tb;
    localparam logic [19:0] a_cnt = `TMC_COUNT_BASE;
    localparam logic [19:0] a_dat = `TMC_DATA_BASE_LO;
    localparam logic [19:0] a_cfg = `TMC_CFG_BASE;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    tmc_pkg::tmc_bus_req_t bus = '0;
    logic [15:0] rd_data;
    logic [7:0] tin = 8'h00;
    logic [7:0] tout;
    logic [7:0] cint;
    logic irq;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int t0;
    int t1;
    logic [15:0] v;
    logic [15:0] w;
    logic [15:0] caps [3];
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    tmc_unit #(.NUM_CH(8)) dut_u (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .bus(bus),
        .rd_data(rd_data),
        .channel_timer_input(tin),
        .channel_timer_output(tout),
        .channel_interrupt(cint),
        .irq(irq)
    );
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_int(input int ch, output int t);
        int i;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end while (cint[ch] !== 1'b1 && i < 3000);
        if (i >= 3000)
            num_errors++;
        t = cyc;
    endtask
    task automatic end_of_test();
        $display("Checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(a_cnt, v);
        chk("count0 reset", 16'hffff, v);
        wr(a_dat, 16'h0007);
        rd(a_dat, v);
        chk("data0 while off", 16'h0000, v);
        wr(`TMC_UNIT_ADDR, 16'h0001);
        rd(a_dat, v);
        chk("data0 reset", 16'h0000, v);
        wr(a_cnt, 16'h1234);
        rd(a_cnt, v);
        chk("count0 read only", 16'hffff, v);
        // A slow tick keeps the shown start values still long enough to read them.
        wr(`TMC_PSC_ADDR, 16'h000a);
        wr(a_cfg + 20'h00002, 16'h0002);
        wr(a_cfg + 20'h00004, 16'h0004);
        wr(`TMC_START_ADDR, 16'h0006);
        rd(a_cnt + 20'h00002, v);
        chk("count1 up start", 16'h0000, v);
        rd(a_cnt + 20'h00004, v);
        chk("count2 down start", 16'hffff, v);
        wr(`TMC_STOP_ADDR, 16'h0006);
        wr(`TMC_PSC_ADDR, 16'h0000);
        wr(a_dat, 16'h0005);
        wr(a_cfg, 16'h0000);
        wr(`TMC_MASK_ADDR, 16'h0001);
        wr(`TMC_START_ADDR, 16'h0001);
        wait_int(0, t0);
        wait_int(0, t1);
        chk("interval period", 16'h0006, 16'(t1 - t0));
        @(posedge ref_clk);
        tin <= 8'h01;
        repeat (8) @(posedge ref_clk);
        rd(a_cnt, v);
        rd(a_dat, w);
        chk("data0 kept", 16'h0005, w);
        chk("irq on", 16'h0001, {15'h0000, irq});
        wr(`TMC_STOP_ADDR, 16'h0001);
        rd(a_cnt, v);
        rd(a_cnt, w);
        chk("count0 held", v, w);
        wr(`TMC_STAT_ADDR, 16'h0001);
        rd(`TMC_STAT_ADDR, v);
        chk("status cleared", 16'h0000, v);
        chk("irq off", 16'h0000, {15'h0000, irq});
        wr(`TMC_START_ADDR, 16'h0002);
        // Each pass has the same length, so the capture intervals match.
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            tin <= 8'h02;
            repeat (20) @(posedge ref_clk);
            tin <= 8'h00;
            repeat (20) @(posedge ref_clk);
            rd(a_dat + 20'h00002, caps[k]);
        end
        chk("capture repeat", caps[1], caps[2]);
        chk("capture range", 16'h0001, {15'h0000, caps[1] > 16'h0010 && caps[1] < 16'h0040});
        // Three captures toggle the channel output three times from its reset level.
        chk("tout1 toggles", 16'h0001, {15'h0000, tout[1]});
        rd(a_cnt + 20'h00002, v);
        rd(a_cnt + 20'h00002, w);
        chk("count1 rising", 16'h0001, {15'h0000, w > v});
        rd(`TMC_STAT_ADDR, v);
        chk("status1 set", 16'h0002, v & 16'h0002);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(`TMC_MASK_ADDR, 16'h0003);
        @(posedge ref_clk);
        #1;
        chk("irq unmasked", 16'h0001, {15'h0000, irq});
        wr(`TMC_DATA_BASE_HI, 16'h0003);
        wr(`TMC_START_ADDR, 16'h0004);
        tin <= 8'h04;
        repeat (5) @(posedge ref_clk);
        rd(a_cnt + 20'h00004, v);
        chk("count2 one-count running", 16'h0001, {15'h0000, v <= 16'h0003});
        repeat (8) @(posedge ref_clk);
        rd(a_cnt + 20'h00004, v);
        chk("count2 one-count wait", 16'hffff, v);
        rd(`TMC_STAT_ADDR, v);
        chk("status2 set", 16'h0004, v & 16'h0004);
        wr(`TMC_STOP_ADDR, 16'h0002);
        wr(`TMC_STAT_ADDR, 16'h00ff);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        wr(`TMC_UNIT_ADDR, 16'h0000);
        repeat (3) @(posedge ref_clk);
        rd(a_cnt + 20'h00002, v);
        chk("count1 unit off", 16'hffff, v);
        rd(a_dat, v);
        chk("data0 unit off", 16'h0000, v);
        wr(`TMC_UNIT_ADDR, 16'h0001);
        rd(a_dat + 20'h00002, v);
        chk("data1 after off", 16'h0000, v);
        end_of_test();
    end
endmodule
